// ---- lacs_pkg.sv ----
// Shared constants, types and carriers of the lead-acid charge sequencer
package lacs_pkg;

    // =====================================================================
    // Widths
    localparam int VCODE_W = 6;
    localparam int ICODE_W = 5;
    localparam int TIME_W = 16;
    localparam int RATIO_W = 16;
    localparam int BSR_W = 16;

    // =====================================================================
    // Voltage codes: 9.523 mV per cell per LSB above 2.0 V/cell
    localparam logic [5:0] VCODE_MIN = 6'h00;
    localparam logic [5:0] VCODE_MAX = 6'h3F;
    localparam logic [5:0] ABSORB_ADDER_RST = 6'h15;
    localparam logic [5:0] EQUALIZE_ADDER_RST = 6'h2A;

    // =====================================================================
    // Temperature compensation
    localparam logic [15:0] RATIO_COLD_LIMIT = 16'h53BD;
    localparam logic [15:0] RATIO_HOT_LIMIT = 16'h0390;
    localparam longint TEMPCO_UV_PER_C = 64'sh0000_0000_0000_0E42;
    localparam longint COMP_SPAN_C = 64'sh0000_0000_0000_00BE;
    localparam longint VCODE_LSB_UV = 64'sh0000_0000_0000_2533;

    // =====================================================================
    // Resistance result scale: ohms = code * Rsense / 750
    localparam logic [9:0] BSR_SCALE = 10'h2EE;

    // =====================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIMER_TICK_NS = 1000000000;
    localparam int TIMER_TICK_CYCLES = (TIMER_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // =====================================================================
    // States
    typedef enum logic [1:0] {
        PH_SUSPENDED,
        PH_ABSORB,
        PH_FLOAT,
        PH_EQUALIZE
    } lacs_phase_t;

    typedef enum logic [1:0] {
        BSR_IDLE,
        BSR_WAIT,
        BSR_MEASURE
    } lacs_bsr_t;

    // =====================================================================
    // Carriers
    typedef struct packed {
        logic vbat_at_target;
        logic ichg_at_goal;
        logic iin_at_limit;
        logic uvcl_at_limit;
        logic ibat_below_cx;
        logic vin_near_battery;
        logic system_fault;
    } lacs_loop_t;

    typedef struct packed {
        logic [4:0] charge_current_goal;
        logic [5:0] float_voltage_setting;
        logic [15:0] max_absorb_time;
        logic [15:0] equalize_time;
        logic temp_comp_en;
        logic suspend_charger;
    } lacs_cfg_t;

    typedef struct packed {
        logic absorb_charge;
        logic float_charge;
        logic equalize_charge;
        logic constant_voltage;
        logic constant_current;
        logic iin_limit_active;
        logic vin_uvcl_active;
        logic charger_suspended;
        logic equalize_req;
        logic bsr_busy;
    } lacs_status_t;

endpackage

// ---- lacs_edge_sync.sv ----
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
module lacs_edge_sync (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Pin and result
    input wire logic pin_in,
    output logic level_out,
    output logic rise_out
);
    import lacs_pkg::*;

    logic meta;
    logic stage2;
    logic stage3;
    logic level;
    logic next_level;
    logic next_rise;
    logic rise;

    // =====================================================================
    // Filter: a change counts once stages two and three agree
    always_comb begin
        next_level = level;
        if (stage2 == stage3) begin
            next_level = stage3;
        end
        next_rise = next_level & ~level;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level <= 1'b0;
            rise <= 1'b0;
        end else begin
            meta <= pin_in;
            stage2 <= meta;
            stage3 <= stage2;
            level <= next_level;
            rise <= next_rise;
        end
    end

    assign level_out = level;
    assign rise_out = rise;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    a_rise_single: assert property (rise_out |=> !rise_out)
        else $error("edge pulse longer than one cycle");

endmodule

// ---- lacs_temp_comp.sv ----
// Charge voltage target: adder, cap and thermistor-based compensation
module lacs_temp_comp #(
    parameter logic [15:0] RATIO_AT_25C = 16'h2AAB
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Settings
    input wire logic [lacs_pkg::VCODE_W-1:0] base_in,
    input wire logic [lacs_pkg::VCODE_W-1:0] adder_in,
    input wire logic comp_en_in,
    input wire logic [lacs_pkg::RATIO_W-1:0] thermistor_ratio_in,
    // Result
    output logic [lacs_pkg::VCODE_W-1:0] applied_voltage_code_out
);
    import lacs_pkg::*;

    if (RATIO_AT_25C > RATIO_COLD_LIMIT || RATIO_AT_25C < RATIO_HOT_LIMIT) begin : g_bad_ratio
        $error("RATIO_AT_25C outside compensation range");
    end

    function automatic logic [5:0] clamp_code(input longint v);
        if (v < 0) begin
            return VCODE_MIN;
        end else if (v > longint'(VCODE_MAX)) begin
            return VCODE_MAX;
        end
        return v[5:0];
    endfunction

    logic [5:0] code;
    logic [5:0] next_code;
    longint sum;
    longint ratio_c;
    longint offset;

    // =====================================================================
    // Colder thermistor means higher ratio and a higher target
    always_comb begin
        sum = longint'(clamp_code(longint'(base_in) + longint'(adder_in)));
        ratio_c = longint'(thermistor_ratio_in);
        if (ratio_c > longint'(RATIO_COLD_LIMIT)) begin
            ratio_c = longint'(RATIO_COLD_LIMIT);
        end else if (ratio_c < longint'(RATIO_HOT_LIMIT)) begin
            ratio_c = longint'(RATIO_HOT_LIMIT);
        end
        offset = 0;
        if (comp_en_in) begin
            // Straight-line fit of the slope over the active ratio span
            offset = ((ratio_c - longint'(RATIO_AT_25C)) * TEMPCO_UV_PER_C * COMP_SPAN_C)
                / (VCODE_LSB_UV * (longint'(RATIO_COLD_LIMIT) - longint'(RATIO_HOT_LIMIT)));
        end
        next_code = clamp_code(sum + offset);
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            code <= VCODE_MIN;
        end else begin
            code <= next_code;
        end
    end

    assign applied_voltage_code_out = code;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    a_comp_off_cap: assert property (!comp_en_in && (base_in + adder_in) > 7'h3F
        |=> applied_voltage_code_out == VCODE_MAX)
        else $error("uncompensated target not capped");
    a_comp_at_25c: assert property (comp_en_in && thermistor_ratio_in == RATIO_AT_25C
        && (7'(base_in) + 7'(adder_in)) <= 7'h3F
        |=> applied_voltage_code_out == $past(base_in + adder_in))
        else $error("target moved at the 25C ratio");
    a_ratio_frozen: assert property (comp_en_in && $stable(base_in)
        && $stable(adder_in) && thermistor_ratio_in > RATIO_COLD_LIMIT
        && $past(thermistor_ratio_in) > RATIO_COLD_LIMIT && $past(comp_en_in)
        |=> $stable(applied_voltage_code_out))
        else $error("compensation moved outside ratio range");

endmodule

// ---- lacs_sequencer.sv ----
// Lead-acid charge sequencer: phases, equalize, suspend and resistance test
module lacs_sequencer #(
    parameter int TICK_CYCLES = lacs_pkg::TIMER_TICK_CYCLES,
    parameter logic [15:0] RATIO_AT_25C = 16'h2AAB
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Host configuration
    input wire lacs_pkg::lacs_cfg_t cfg_in,
    input wire logic absorb_adder_wr_in,
    input wire logic equalize_adder_wr_in,
    input wire logic [lacs_pkg::VCODE_W-1:0] adder_wdata_in,
    input wire logic run_bsr_in,
    // Analog loops and charge cycle
    input wire lacs_pkg::lacs_loop_t loop_in,
    input wire logic charge_start_in,
    input wire logic [lacs_pkg::RATIO_W-1:0] thermistor_ratio_in,
    input wire logic equalize_request_pin_in,
    // Resistance measurement front end
    input wire logic bsr_meas_done_in,
    input wire logic [lacs_pkg::BSR_W-1:0] bsr_delta_v_in,
    input wire logic [lacs_pkg::BSR_W-1:0] bsr_delta_i_in,
    // Status and results
    output lacs_pkg::lacs_status_t status_out,
    output logic [lacs_pkg::VCODE_W-1:0] absorb_voltage_adder_out,
    output logic [lacs_pkg::VCODE_W-1:0] equalize_voltage_adder_out,
    output logic [lacs_pkg::BSR_W-1:0] resistance_code_out,
    output logic [lacs_pkg::BSR_W-1:0] resistance_test_current_step_out,
    // Regulation loop drive
    output logic [lacs_pkg::VCODE_W-1:0] applied_voltage_code_out,
    output logic [lacs_pkg::ICODE_W-1:0] charge_current_code_out,
    output logic charger_enable_out,
    output logic bsr_measure_out
);
    import lacs_pkg::*;

    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("TICK_CYCLES must be at least one");
    end

    function automatic logic [15:0] scale_resistance(input logic [15:0] dv, input logic [15:0] di);
        logic [31:0] q;
        q = 32'hFFFF_FFFF;
        if (di != 16'h0000) begin
            q = (32'(dv) * 32'(BSR_SCALE)) / 32'(di);
        end
        if (q > 32'h0000_FFFF) begin
            return 16'hFFFF;
        end
        return q[15:0];
    endfunction

    // =====================================================================
    // Pin synchroniser
    logic eq_rise;

    lacs_edge_sync u_eq_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .pin_in(equalize_request_pin_in),
        .level_out(),
        .rise_out(eq_rise)
    );

    // =====================================================================
    // Adder registers
    logic [5:0] absorb_adder;
    logic [5:0] equalize_adder;
    logic [5:0] next_absorb_adder;
    logic [5:0] next_equalize_adder;

    always_comb begin
        next_absorb_adder = absorb_adder;
        next_equalize_adder = equalize_adder;
        if (absorb_adder_wr_in) begin
            next_absorb_adder = adder_wdata_in;
        end
        if (equalize_adder_wr_in) begin
            next_equalize_adder = adder_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            absorb_adder <= ABSORB_ADDER_RST;
            equalize_adder <= EQUALIZE_ADDER_RST;
        end else begin
            absorb_adder <= next_absorb_adder;
            equalize_adder <= next_equalize_adder;
        end
    end

    // =====================================================================
    // Phase machine with one-second timer
    lacs_phase_t phase;
    lacs_phase_t next_phase;
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic [15:0] phase_timer;
    logic [15:0] next_phase_timer;
    logic absorb_reached;
    logic next_absorb_reached;
    logic eq_req;
    logic next_eq_req;
    logic suspend_cause;
    logic absorb_reached_now;
    logic eq_done;

    always_comb begin
        suspend_cause = loop_in.vin_near_battery | cfg_in.suspend_charger
            | loop_in.system_fault;
        absorb_reached_now = absorb_reached | loop_in.vbat_at_target;
        eq_done = phase == PH_EQUALIZE && phase_timer >= cfg_in.equalize_time;
        next_phase = phase;
        if (suspend_cause) begin
            next_phase = PH_SUSPENDED;
        end else begin
            case (phase)
                PH_SUSPENDED: begin
                    if (charge_start_in) begin
                        next_phase = PH_ABSORB;
                    end
                end
                PH_ABSORB: begin
                    if (absorb_reached_now && (phase_timer >= cfg_in.max_absorb_time
                        || loop_in.ibat_below_cx)) begin
                        next_phase = PH_FLOAT;
                    end
                end
                PH_FLOAT: begin
                    // No timed exit: float lasts until equalize entry or a suspend cause
                    if (eq_req && loop_in.vbat_at_target) begin
                        next_phase = PH_EQUALIZE;
                    end
                end
                PH_EQUALIZE: begin
                    if (eq_done) begin
                        next_phase = PH_FLOAT;
                    end
                end
                default: begin
                    next_phase = PH_SUSPENDED;
                end
            endcase
        end
        next_tick_cnt = tick_cnt + 32'd1;
        next_phase_timer = phase_timer;
        if (next_phase != phase) begin
            next_tick_cnt = 32'd0;
            next_phase_timer = 16'h0000;
        end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            next_tick_cnt = 32'd0;
            if (phase_timer != 16'hFFFF) begin
                next_phase_timer = phase_timer + 16'h0001;
            end
        end
        next_absorb_reached = (phase == PH_ABSORB) && next_phase == PH_ABSORB
            && absorb_reached_now;
        // A fresh edge in the completion cycle survives the clear
        next_eq_req = (eq_req & ~(eq_done & ~suspend_cause)) | eq_rise;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            phase <= PH_SUSPENDED;
            tick_cnt <= 32'd0;
            phase_timer <= 16'h0000;
            absorb_reached <= 1'b0;
            eq_req <= 1'b0;
        end else begin
            phase <= next_phase;
            tick_cnt <= next_tick_cnt;
            phase_timer <= next_phase_timer;
            absorb_reached <= next_absorb_reached;
            eq_req <= next_eq_req;
        end
    end

    // =====================================================================
    // Resistance measurement; the charger pauses while it runs
    lacs_bsr_t bsr_state;
    lacs_bsr_t next_bsr_state;
    logic [15:0] res_code;
    logic [15:0] next_res_code;
    logic [15:0] res_step;
    logic [15:0] next_res_step;
    logic charging;

    always_comb begin
        charging = phase != PH_SUSPENDED && !suspend_cause;
        next_bsr_state = bsr_state;
        next_res_code = res_code;
        next_res_step = res_step;
        case (bsr_state)
            BSR_IDLE: begin
                if (run_bsr_in) begin
                    next_bsr_state = charging ? BSR_MEASURE : BSR_WAIT;
                end
            end
            BSR_WAIT: begin
                if (charge_start_in && !suspend_cause) begin
                    next_bsr_state = BSR_MEASURE;
                end
            end
            BSR_MEASURE: begin
                if (suspend_cause) begin
                    next_bsr_state = BSR_WAIT;
                end else if (bsr_meas_done_in) begin
                    next_bsr_state = BSR_IDLE;
                    next_res_code = scale_resistance(bsr_delta_v_in, bsr_delta_i_in);
                    next_res_step = bsr_delta_i_in;
                end
            end
            default: begin
                next_bsr_state = BSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bsr_state <= BSR_IDLE;
            res_code <= 16'h0000;
            res_step <= 16'h0000;
        end else begin
            bsr_state <= next_bsr_state;
            res_code <= next_res_code;
            res_step <= next_res_step;
        end
    end

    // =====================================================================
    // Voltage target and status
    logic [5:0] phase_adder;
    lacs_status_t status;
    lacs_status_t next_status;
    logic active_next;

    always_comb begin
        phase_adder = 6'h00;
        if (phase == PH_ABSORB) begin
            phase_adder = absorb_adder;
        end else if (phase == PH_EQUALIZE) begin
            phase_adder = equalize_adder;
        end
        active_next = next_phase != PH_SUSPENDED;
        next_status.absorb_charge = next_phase == PH_ABSORB;
        next_status.float_charge = next_phase == PH_FLOAT;
        next_status.equalize_charge = next_phase == PH_EQUALIZE;
        next_status.constant_voltage = active_next && loop_in.vbat_at_target;
        next_status.constant_current = active_next && loop_in.ichg_at_goal;
        next_status.iin_limit_active = active_next && loop_in.iin_at_limit;
        next_status.vin_uvcl_active = active_next && loop_in.uvcl_at_limit;
        next_status.charger_suspended = !active_next;
        next_status.equalize_req = next_eq_req;
        next_status.bsr_busy = next_bsr_state != BSR_IDLE;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    lacs_temp_comp #(
        .RATIO_AT_25C(RATIO_AT_25C)
    ) u_comp (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .base_in(cfg_in.float_voltage_setting),
        .adder_in(phase_adder),
        .comp_en_in(cfg_in.temp_comp_en),
        .thermistor_ratio_in(thermistor_ratio_in),
        .applied_voltage_code_out(applied_voltage_code_out)
    );

    // Loops throttle current themselves when input limits engage
    assign charger_enable_out = phase != PH_SUSPENDED && bsr_state != BSR_MEASURE;
    assign charge_current_code_out = charger_enable_out ? cfg_in.charge_current_goal : 5'h00;
    assign bsr_measure_out = bsr_state == BSR_MEASURE;
    assign status_out = status;
    assign absorb_voltage_adder_out = absorb_adder;
    assign equalize_voltage_adder_out = equalize_adder;
    assign resistance_code_out = res_code;
    assign resistance_test_current_step_out = res_step;

    // =====================================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_absorb_to_float;
        phase == PH_ABSORB ##1 phase == PH_FLOAT;
    endsequence

    a_start_absorb: assert property (phase == PH_SUSPENDED && charge_start_in
        && !suspend_cause |=> phase == PH_ABSORB && status_out.absorb_charge
        && phase_timer == 16'h0000)
        else $error("charge start did not enter absorb");
    a_absorb_exit: assert property (s_absorb_to_float |-> $past(absorb_reached_now))
        else $error("absorb left before target voltage");
    a_float_holds: assert property (phase == PH_FLOAT && !suspend_cause && !eq_req
        |=> phase == PH_FLOAT && status_out.float_charge)
        else $error("float phase left without cause");
    a_eq_entry: assert property (phase == PH_FLOAT && eq_req && loop_in.vbat_at_target
        && !suspend_cause |=> phase == PH_EQUALIZE && phase_timer == 16'h0000)
        else $error("equalize not entered on request");
    a_eq_exit: assert property (eq_done && !suspend_cause
        |=> phase == PH_FLOAT && eq_req == $past(eq_rise))
        else $error("equalize end mishandled");
    a_suspend_any: assert property (suspend_cause
        |=> phase == PH_SUSPENDED && status_out.charger_suspended && !charger_enable_out)
        else $error("suspend cause did not stop charger");
    a_bsr_queued: assert property (bsr_state == BSR_WAIT && !charge_start_in
        |=> bsr_state != BSR_MEASURE)
        else $error("queued measurement ran early");
    a_bsr_result: assert property (bsr_state == BSR_MEASURE && bsr_meas_done_in
        && !suspend_cause && bsr_delta_i_in == 16'h0001 && bsr_delta_v_in <= 16'h0057
        |=> resistance_code_out == 16'(32'($past(bsr_delta_v_in)) * 32'd750)
        && resistance_test_current_step_out == 16'h0001 && !bsr_measure_out)
        else $error("resistance result wrong");
    a_limit_flags: assert property (phase != PH_SUSPENDED && !suspend_cause
        && loop_in.iin_at_limit |=> status_out.iin_limit_active)
        else $error("input limit flag missing");

endmodule

// ---- lacs_eq_requester.sv ----
// Far-side model: the host that drives the equalize request pin
module lacs_eq_requester (
    // Clock and control
    input wire logic clk_in,
    input wire logic request_in,
    input wire logic eq_active_in,
    // Pin
    output logic pin_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin_out = 1'b0;
    // Pin is held high while the equalize phase runs, else follows the request
    always @(negedge clk_in) begin
        pin_out <= request_in | (pin_out & eq_active_in);
    end
endmodule

// ---- lacs_sequencer_test.sv ----
// Self-checking bench of the lead-acid charge sequencer
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("BAD %0t got %h", $time, a); end end
`define WAITF(c) begin n = 0; while ((c) !== 1'b1 && n < 40) begin @(negedge clk_in); n++; end \
    if ((c) !== 1'b1) begin errors++; $display("BAD %0t timeout", $time); \
    tally_and_finish(); end end
module lacs_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    import lacs_pkg::*;
    // ==========================================
    // Stimulus and observed signals
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic ew = 1'b0;
    logic aw = 1'b0;
    logic [15:0] ratio = 16'h2AAB;
    logic [15:0] dv = 16'h0004;
    logic [15:0] di = 16'h0003;
    logic run = 1'b0;
    logic start = 1'b0;
    logic done = 1'b0;
    logic req = 1'b0;
    logic pin, en, meas;
    lacs_cfg_t cfg = '{5'h1F, 6'h15, 16'h0003, 16'h0002, 1'b0, 1'b0};
    lacs_loop_t lp = '0;
    lacs_status_t st;
    logic [5:0] aadd, eadd, code;
    logic [15:0] rcode, rstep;
    logic [4:0] icode;
    int errors = 0;
    int total_checks = 0;
    int n;
    always #5 clk_in = ~clk_in;
    // Short timer tick keeps the absorb and equalize timers in a few cycles
    lacs_sequencer #(.TICK_CYCLES(4)) DUT (.clk_in(clk_in), .rstn_in(rstn_in), .cfg_in(cfg),
        .absorb_adder_wr_in(aw), .equalize_adder_wr_in(ew), .adder_wdata_in(6'h30),
        .run_bsr_in(run), .loop_in(lp), .charge_start_in(start), .thermistor_ratio_in(ratio),
        .equalize_request_pin_in(pin), .bsr_meas_done_in(done), .bsr_delta_v_in(dv),
        .bsr_delta_i_in(di), .status_out(st), .absorb_voltage_adder_out(aadd),
        .equalize_voltage_adder_out(eadd), .resistance_code_out(rcode),
        .resistance_test_current_step_out(rstep), .applied_voltage_code_out(code),
        .charge_current_code_out(icode), .charger_enable_out(en), .bsr_measure_out(meas));
    lacs_eq_requester EQ (.clk_in(clk_in), .request_in(req), .eq_active_in(st.equalize_charge),
        .pin_out(pin));
    // ==========================================
    // Scenarios
    task automatic tick(input int k);
        repeat (k) @(negedge clk_in);
    endtask
    task automatic t_absorb();
        `CHK(aadd, ABSORB_ADDER_RST)
        `CHK(eadd, EQUALIZE_ADDER_RST)
        start = 1'b1;
        tick(1);
        start = 1'b0;
        `WAITF(st.absorb_charge)
        tick(2);
        `CHK(code, 6'h2A)
        `CHK(icode, 5'h1F)
        lp.iin_at_limit = 1'b1;
        lp.uvcl_at_limit = 1'b1;
        lp.ibat_below_cx = 1'b1;
        tick(20);
        `CHK(st.iin_limit_active, 1'b1)
        `CHK(st.vin_uvcl_active, 1'b1)
        `CHK(st.absorb_charge, 1'b1)
        lp = '0;
        lp.vbat_at_target = 1'b1;
        `WAITF(st.float_charge)
        tick(2);
        `CHK(code, 6'h15)
    endtask
    task automatic t_equalize();
        lp.vbat_at_target = 1'b0;
        lp.ichg_at_goal = 1'b1;
        ew = 1'b1;
        tick(1);
        ew = 1'b0;
        req = 1'b1;
        tick(30);
        `CHK(st.constant_current, 1'b1)
        `CHK(st.float_charge, 1'b1)
        `CHK(st.equalize_req, 1'b1)
        lp.vbat_at_target = 1'b1;
        `WAITF(st.equalize_charge)
        req = 1'b0;
        tick(2);
        `CHK(code, 6'h3F)
        `CHK(st.constant_voltage, 1'b1)
        `WAITF(st.float_charge)
        `CHK(n >= 6 && n <= 8, 1'b1)
        tick(10);
        `CHK(st.equalize_req, 1'b0)
        `CHK(st.float_charge, 1'b1)
    endtask
    task automatic t_suspend_bsr();
        cfg.suspend_charger = 1'b1;
        tick(2);
        `CHK(st.charger_suspended, 1'b1)
        `CHK(en, 1'b0)
        run = 1'b1;
        tick(1);
        run = 1'b0;
        tick(4);
        `CHK(meas, 1'b0)
        `CHK(en, 1'b0)
        `CHK(st.bsr_busy, 1'b1)
        cfg.suspend_charger = 1'b0;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        `WAITF(meas)
        `CHK(en, 1'b0)
        done = 1'b1;
        tick(1);
        done = 1'b0;
        tick(1);
        `CHK(rcode, 16'h03E8)
        `CHK(rstep, 16'h0003)
        dv = 16'h0050;
        di = 16'h0001;
        run = 1'b1;
        tick(1);
        run = 1'b0;
        `CHK(meas, 1'b1)
        done = 1'b1;
        tick(1);
        done = 1'b0;
        tick(1);
        `CHK(rcode, 16'hEA60)
        `CHK(rstep, 16'h0001)
        `CHK(st.bsr_busy, 1'b0)
        lp.vin_near_battery = 1'b1;
        tick(2);
        `CHK(st.charger_suspended, 1'b1)
    endtask
    task automatic t_comp_reset();
        logic [5:0] cold;
        lp = '0;
        cfg.temp_comp_en = 1'b1;
        tick(2);
        `CHK(code, 6'h15)
        ratio = RATIO_COLD_LIMIT;
        tick(2);
        cold = code;
        `CHK(cold > 6'h15, 1'b1)
        ratio = 16'hFFFF;
        tick(3);
        `CHK(code, cold)
        ratio = RATIO_HOT_LIMIT;
        tick(2);
        `CHK(code, VCODE_MIN)
        aw = 1'b1;
        tick(1);
        aw = 1'b0;
        `CHK(aadd, 6'h30)
        rstn_in = 1'b0;
        tick(2);
        rstn_in = 1'b1;
        tick(2);
        `CHK(aadd, ABSORB_ADDER_RST)
        `CHK(st.charger_suspended, 1'b1)
        `CHK(en, 1'b0)
        start = 1'b1;
        tick(1);
        start = 1'b0;
        `CHK(st.absorb_charge, 1'b1)
        lp.vbat_at_target = 1'b1;
        lp.ibat_below_cx = 1'b1;
        tick(2);
        `CHK(st.float_charge, 1'b1)
        lp.system_fault = 1'b1;
        tick(2);
        `CHK(st.charger_suspended, 1'b1)
        `CHK(en, 1'b0)
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        tick(5);
        rstn_in = 1'b1;
        tick(2);
        t_absorb();
        t_equalize();
        t_suspend_bsr();
        t_comp_reset();
        tally_and_finish();
    end
endmodule
